/* core/tmc_pkg.sv */
// Package: constants, encodings and carriers of the temperature monitor control block
package tmc_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned EIGHTH_SEC_MS = 125;
	localparam int unsigned EIGHTH_SEC_CYC = (EIGHTH_SEC_MS * 1000000) / CLK_PERIOD_NS;
	localparam int unsigned RATE_MAX_SHIFT = 7;
	localparam int unsigned ONESHOT_WAIT_MS = 170;

	// ---------------------------------------------------------------
	// Command bytes
	// ---------------------------------------------------------------
	localparam logic [7:0] LOCAL_RESULT_CMD = 8'h00;
	localparam logic [7:0] REMOTE_RESULT_CMD = 8'h01;
	localparam logic [7:0] FLAGS_READ_CMD = 8'h02;
	localparam logic [7:0] CONFIG_READ_CMD = 8'h03;
	localparam logic [7:0] INTERVAL_READ_CMD = 8'h04;
	localparam logic [7:0] LOCAL_UPPER_READ_CMD = 8'h05;
	localparam logic [7:0] LOCAL_LOWER_READ_CMD = 8'h06;
	localparam logic [7:0] REMOTE_UPPER_READ_CMD = 8'h07;
	localparam logic [7:0] REMOTE_LOWER_READ_CMD = 8'h08;
	localparam logic [7:0] CONFIG_WRITE_CMD = 8'h09;
	localparam logic [7:0] INTERVAL_WRITE_CMD = 8'h0A;
	localparam logic [7:0] LOCAL_UPPER_WRITE_CMD = 8'h0B;
	localparam logic [7:0] LOCAL_LOWER_WRITE_CMD = 8'h0C;
	localparam logic [7:0] REMOTE_UPPER_WRITE_CMD = 8'h0D;
	localparam logic [7:0] REMOTE_LOWER_WRITE_CMD = 8'h0E;
	localparam logic [7:0] SINGLE_CONVERSION_CMD = 8'h0F;
	localparam logic [6:0] ALERT_RESPONSE_ADDR = 7'h0C;

	// ---------------------------------------------------------------
	// Reset values and field positions
	// ---------------------------------------------------------------
	localparam logic [7:0] INTERVAL_RST = 8'h02;
	localparam logic [7:0] UPPER_RST = 8'h7F;
	localparam logic [7:0] LOWER_RST = 8'hC9;
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam int unsigned CFG_MASK_BIT = 7;
	localparam int unsigned CFG_SLEEP_BIT = 6;
	localparam int unsigned ST_BUSY_BIT = 7;
	localparam int unsigned ST_TRIP_LSB = 3;
	localparam int unsigned ST_OPEN_BIT = 2;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		KIND_WRITE = 2'h0,
		KIND_READ = 2'h1,
		KIND_SEND = 2'h2,
		KIND_ALERT = 2'h3
	} tmc_kind_e;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b01,
		CONV_RUN = 2'b10
	} tmc_conv_e;

	typedef struct packed {
		tmc_kind_e kind;
		logic [7:0] cmd;
		logic [7:0] data;
	} tmc_req_s;

	typedef struct packed {
		logic [7:0] local_t;
		logic [7:0] remote_t;
		logic open;
	} tmc_adc_s;

endpackage : tmc_pkg

/* core/tmc_top.sv */
// Conversion scheduler, limit alarms, status flags and latched alert of the monitor
//
// Contract
// - Rate uses three low bits; codes 0-7 give 1/16 to 8 conversions per second.
// - Rate setting resets to 02h, one conversion every four seconds.
// - Each channel result compared with own limits, inclusive; trip sets flag and alert.
// - Upper limits reset 7Fh, lower limits C9h; separate write and read commands.
// - Send byte 0Fh starts a conversion and stores nothing.
// - One-shot while idle in free-running starts a conversion at once.
// - One-shot during a conversion is dropped without effect.
// - In software sleep one-shot runs one two-channel cycle, then sleeps again.
// - Hardware sleep blocks one-shot conversions.
// - Status bits: busy 7, local trips 6/5, remote trips 4/3, open 2.
// - Status is read-only; all trip and fault flags clear at reset.
// - Status read clears trip flags unless condition persists; else they stick.
// - Open flag survives status reads, cleared only by reset.
// - Alert is active-low open-drain: pulls low or floats.
// - Trips or open diode raise alert; busy alone never does.
// - Alert stays latched; status read does not release it, response read does.
// - Response address read returns own address in bits 7-1, bit 0 one.
// - After response read alert releases unless its condition persists.
// - Hardware sleep low inhibits conversions; running one abandoned, results unchanged.
// - Config bit 7 masks alert; bit 6 enters software sleep.
// - Results and limits are signed 8-bit, one count per degree.
`timescale 1ns/100ps
module tmc_top #(
	parameter int unsigned EIGHTH_CYC = tmc_pkg::EIGHTH_SEC_CYC
) (
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic LINK_CLK_I,
	input wire logic HW_SLEEP_N_I,
	input wire logic [6:0] DEV_ADDR_I,
	input wire logic LNK_REQ_I,
	input wire tmc_pkg::tmc_req_s LNK_REQ_DATA_I,
	output logic LNK_BUSY_O,
	output logic LNK_ACK_O,
	output logic LNK_NACK_O,
	output logic [7:0] LNK_RDATA_O,
	output logic CONV_START_O,
	input wire logic ADC_DONE_I,
	input wire tmc_pkg::tmc_adc_s ADC_I,
	output logic ALERT_N_O,
	output logic ALERT_OE_O
);
	import tmc_pkg::*;

	// ---------------------------------------------------------------
	// Reset synchronisers, one per domain
	// ---------------------------------------------------------------
	logic [1:0] rst_core_reg, rst_link_reg;
	logic rst_n, lrst_n;

	always_ff @(posedge MCLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			rst_core_reg <= 2'h0;
		else
			rst_core_reg <= {rst_core_reg[0], 1'b1};
	end

	always_ff @(posedge LINK_CLK_I or negedge RSTN_I)
	begin
		if (!RSTN_I)
			rst_link_reg <= 2'h0;
		else
			rst_link_reg <= {rst_link_reg[0], 1'b1};
	end

	assign rst_n = rst_core_reg[1];
	assign lrst_n = rst_link_reg[1];

	// ---------------------------------------------------------------
	// Link side: holds the request until the core answers
	// ---------------------------------------------------------------
	logic req_tgl_reg, req_tgl_next, lbusy_reg, lbusy_next, lack_reg, lack_next;
	logic lnack_reg, lnack_next, ack_tgl_reg, rsp_nack_reg;
	tmc_req_s hold_reg, hold_next;
	logic [2:0] ack_sync_reg;
	logic [7:0] lrdata_reg, lrdata_next, rsp_data_reg;

	always_comb
	begin
		req_tgl_next = req_tgl_reg;
		hold_next = hold_reg;
		lbusy_next = lbusy_reg;
		lack_next = 1'b0;
		lnack_next = lnack_reg;
		lrdata_next = lrdata_reg;
		// New requests while one is in flight are ignored
		if (LNK_REQ_I && !lbusy_reg)
		begin
			hold_next = LNK_REQ_DATA_I;
			req_tgl_next = ~req_tgl_reg;
			lbusy_next = 1'b1;
		end
		// Response word is quiet until the next request, so it can be taken here
		if (ack_sync_reg[2] != ack_sync_reg[1])
		begin
			lbusy_next = 1'b0;
			lack_next = 1'b1;
			lnack_next = rsp_nack_reg;
			lrdata_next = rsp_data_reg;
		end
	end

	always_ff @(posedge LINK_CLK_I or negedge lrst_n)
	begin
		if (!lrst_n)
		begin
			req_tgl_reg <= 1'b0;
			hold_reg <= '0;
			ack_sync_reg <= 3'h0;
			lbusy_reg <= 1'b0;
			lack_reg <= 1'b0;
			lnack_reg <= 1'b0;
			lrdata_reg <= 8'h00;
		end
		else
		begin
			req_tgl_reg <= req_tgl_next;
			hold_reg <= hold_next;
			ack_sync_reg <= {ack_sync_reg[1:0], ack_tgl_reg};
			lbusy_reg <= lbusy_next;
			lack_reg <= lack_next;
			lnack_reg <= lnack_next;
			lrdata_reg <= lrdata_next;
		end
	end

	assign LNK_BUSY_O = lbusy_reg;
	assign LNK_ACK_O = lack_reg;
	assign LNK_NACK_O = lnack_reg;
	assign LNK_RDATA_O = lrdata_reg;

	// ---------------------------------------------------------------
	// Core side: pin and toggle synchronisers
	// ---------------------------------------------------------------
	logic [2:0] req_sync_reg;
	logic [1:0] sleep_sync_reg;
	logic [6:0] addr_s1_reg, addr_s2_reg;
	logic take, hw_sleep;

	assign take = req_sync_reg[2] != req_sync_reg[1];
	assign hw_sleep = !sleep_sync_reg[1];

	// ---------------------------------------------------------------
	// Registers, scheduler and conversion control
	// ---------------------------------------------------------------
	logic [7:0] cfg_reg, cfg_next, rate_reg, rate_next;
	logic [7:0] lup_reg, lup_next, llo_reg, llo_next, rup_reg, rup_next, rlo_reg, rlo_next;
	logic [7:0] lres_reg, lres_next, rres_reg, rres_next;
	logic [31:0] tick_reg, tick_next, interval;
	tmc_conv_e conv_reg, conv_next;
	logic start_reg, start_next, done, wr, oneshot;

	assign wr = take && hold_reg.kind == KIND_WRITE;
	assign oneshot = take && hold_reg.cmd == SINGLE_CONVERSION_CMD
		&& (hold_reg.kind == KIND_SEND || hold_reg.kind == KIND_WRITE);
	// One short: the edge that loads the counter is the first cycle of the interval
	assign interval = (EIGHTH_CYC << (RATE_MAX_SHIFT - rate_reg[2:0]))
		- 32'h0000_0001;
	assign done = conv_reg == CONV_RUN && ADC_DONE_I && !hw_sleep;

	always_comb
	begin
		cfg_next = cfg_reg;
		rate_next = rate_reg;
		lup_next = lup_reg;
		llo_next = llo_reg;
		rup_next = rup_reg;
		rlo_next = rlo_reg;
		lres_next = lres_reg;
		rres_next = rres_reg;
		conv_next = conv_reg;
		start_next = 1'b0;
		tick_next = tick_reg;
		if (wr)
		begin
			unique case (hold_reg.cmd)
				CONFIG_WRITE_CMD: cfg_next = hold_reg.data;
				INTERVAL_WRITE_CMD: rate_next = hold_reg.data;
				LOCAL_UPPER_WRITE_CMD: lup_next = hold_reg.data;
				LOCAL_LOWER_WRITE_CMD: llo_next = hold_reg.data;
				REMOTE_UPPER_WRITE_CMD: rup_next = hold_reg.data;
				REMOTE_LOWER_WRITE_CMD: rlo_next = hold_reg.data;
				default: ;
			endcase
		end
		if (tick_reg != 32'h0000_0000)
			tick_next = tick_reg - 32'h0000_0001;
		unique case (conv_reg)
			CONV_IDLE:
			begin
				// Software sleep stops the schedule but not the one-shot
				if (!hw_sleep
					&& (oneshot || (tick_reg == 32'h0000_0000 && !cfg_reg[CFG_SLEEP_BIT])))
				begin
					conv_next = CONV_RUN;
					start_next = 1'b1;
					tick_next = interval;
				end
			end
			CONV_RUN:
			begin
				// A one-shot here falls through untouched
				if (hw_sleep)
					conv_next = CONV_IDLE;
				else if (done)
				begin
					conv_next = CONV_IDLE;
					lres_next = ADC_I.local_t;
					rres_next = ADC_I.remote_t;
				end
			end
		endcase
		if (hw_sleep)
			tick_next = interval;
	end

	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cfg_reg <= CONFIG_RST;
			rate_reg <= INTERVAL_RST;
			lup_reg <= UPPER_RST;
			llo_reg <= LOWER_RST;
			rup_reg <= UPPER_RST;
			rlo_reg <= LOWER_RST;
			lres_reg <= 8'h00;
			rres_reg <= 8'h00;
			tick_reg <= 32'h0000_0000;
			conv_reg <= CONV_IDLE;
			start_reg <= 1'b0;
			req_sync_reg <= 3'h0;
			sleep_sync_reg <= 2'h3;
			addr_s1_reg <= 7'h00;
			addr_s2_reg <= 7'h00;
		end
		else
		begin
			cfg_reg <= cfg_next;
			rate_reg <= rate_next;
			lup_reg <= lup_next;
			llo_reg <= llo_next;
			rup_reg <= rup_next;
			rlo_reg <= rlo_next;
			lres_reg <= lres_next;
			rres_reg <= rres_next;
			tick_reg <= tick_next;
			conv_reg <= conv_next;
			start_reg <= start_next;
			req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
			sleep_sync_reg <= {sleep_sync_reg[0], HW_SLEEP_N_I};
			addr_s1_reg <= DEV_ADDR_I;
			addr_s2_reg <= addr_s1_reg;
		end
	end

	assign CONV_START_O = start_reg;

	// ---------------------------------------------------------------
	// Limit flags, alert latch and answers
	// ---------------------------------------------------------------
	logic [3:0] trip_reg, trip_next, cond_reg, cond_next, cmp;
	logic open_reg, open_next, latch_reg, latch_next, oe_reg, oe_next, low_reg;
	logic ack_tgl_next, rsp_nack_next, st_rd, ara;
	logic [7:0] rsp_data_next, status;

	// Signed compares, inclusive at both limits
	assign cmp[3] = $signed(ADC_I.local_t) >= $signed(lup_reg);
	assign cmp[2] = $signed(ADC_I.local_t) <= $signed(llo_reg);
	assign cmp[1] = $signed(ADC_I.remote_t) >= $signed(rup_reg);
	assign cmp[0] = $signed(ADC_I.remote_t) <= $signed(rlo_reg);
	assign status = {conv_reg == CONV_RUN, trip_reg, open_reg, 2'h0};
	assign st_rd = take && hold_reg.kind == KIND_READ && hold_reg.cmd == FLAGS_READ_CMD;
	assign ara = take && hold_reg.kind == KIND_ALERT;

	always_comb
	begin
		cond_next = cond_reg;
		trip_next = trip_reg;
		open_next = open_reg;
		latch_next = latch_reg;
		ack_tgl_next = ack_tgl_reg;
		rsp_nack_next = rsp_nack_reg;
		rsp_data_next = rsp_data_reg;
		if (st_rd)
			trip_next = trip_reg & cond_reg;
		if (ara)
		begin
			// Only a device with its alert up answers the response address
			rsp_nack_next = !latch_reg;
			rsp_data_next = {addr_s2_reg, 1'b1};
			latch_next = (|cond_reg) || open_reg;
		end
		else if (take)
		begin
			rsp_nack_next = 1'b0;
			unique case (hold_reg.cmd)
				LOCAL_RESULT_CMD: rsp_data_next = lres_reg;
				REMOTE_RESULT_CMD: rsp_data_next = rres_reg;
				FLAGS_READ_CMD: rsp_data_next = status;
				CONFIG_READ_CMD: rsp_data_next = cfg_reg;
				INTERVAL_READ_CMD: rsp_data_next = rate_reg;
				LOCAL_UPPER_READ_CMD: rsp_data_next = lup_reg;
				LOCAL_LOWER_READ_CMD: rsp_data_next = llo_reg;
				REMOTE_UPPER_READ_CMD: rsp_data_next = rup_reg;
				REMOTE_LOWER_READ_CMD: rsp_data_next = rlo_reg;
				default: rsp_data_next = 8'h00;
			endcase
		end
		if (take)
			ack_tgl_next = ~ack_tgl_reg;
		// Set after clear, so a trip in the clearing cycle is kept
		if (done)
		begin
			cond_next = cmp;
			trip_next = trip_next | cmp;
			open_next = open_reg | ADC_I.open;
			if (((|cmp) || ADC_I.open) && !cfg_reg[CFG_MASK_BIT])
				latch_next = 1'b1;
		end
		oe_next = latch_next && !cfg_reg[CFG_MASK_BIT];
	end

	always_ff @(posedge MCLK_I or negedge rst_n)
	begin
		if (!rst_n)
		begin
			trip_reg <= 4'h0;
			cond_reg <= 4'h0;
			open_reg <= 1'b0;
			latch_reg <= 1'b0;
			oe_reg <= 1'b0;
			low_reg <= 1'b0;
			ack_tgl_reg <= 1'b0;
			rsp_nack_reg <= 1'b0;
			rsp_data_reg <= 8'h00;
		end
		else
		begin
			trip_reg <= trip_next;
			cond_reg <= cond_next;
			open_reg <= open_next;
			latch_reg <= latch_next;
			oe_reg <= oe_next;
			low_reg <= 1'b0;
			ack_tgl_reg <= ack_tgl_next;
			rsp_nack_reg <= rsp_nack_next;
			rsp_data_reg <= rsp_data_next;
		end
	end

	// Open drain: the pin value is always low, only the enable moves
	assign ALERT_N_O = low_reg;
	assign ALERT_OE_O = oe_reg;

endmodule : tmc_top

/* test/tmc_checker.sv */
// Port assertions of the monitor control block
`timescale 1ns/100ps
module tmc_checker
	import tmc_pkg::*;
(
	input wire logic MCLK_I,
	input wire logic RSTN_I,
	input wire logic LINK_CLK_I,
	input wire logic HW_SLEEP_N_I,
	input wire logic [6:0] DEV_ADDR_I,
	input wire logic LNK_REQ_I,
	input wire tmc_req_s LNK_REQ_DATA_I,
	input wire logic LNK_BUSY_O,
	input wire logic LNK_ACK_O,
	input wire logic LNK_NACK_O,
	input wire logic [7:0] LNK_RDATA_O,
	input wire logic CONV_START_O,
	input wire logic ADC_DONE_I,
	input wire tmc_adc_s ADC_I,
	input wire logic ALERT_N_O,
	input wire logic ALERT_OE_O
);
	// -------------------------------------------
	// Checks
	// -------------------------------------------
	tmc_req_s req_reg;
	tmc_req_s req_next;
	// Kind of the transfer now in flight, to judge its answer
	always_comb req_next = (LNK_REQ_I && !LNK_BUSY_O) ? LNK_REQ_DATA_I : req_reg;
	always_ff @(posedge LINK_CLK_I or negedge RSTN_I)
		if (!RSTN_I) req_reg <= '0;
		else req_reg <= req_next;
	sequence s_take;
		LNK_REQ_I && !LNK_BUSY_O;
	endsequence
	sequence s_ack;
		LNK_ACK_O;
	endsequence
	a_take_busy: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
		s_take |=> LNK_BUSY_O) else $error("taken without busy");
	a_answer_bound: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
		s_take |-> ##[1:12] s_ack) else $error("request not answered");
	a_ack_pulse: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
		s_ack |-> !LNK_BUSY_O ##1 !LNK_ACK_O) else $error("ack not a pulse");
	a_answer_hold: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
		!LNK_ACK_O |-> $stable(LNK_RDATA_O) && $stable(LNK_NACK_O)) else $error("answer moved");
	a_alert_answer: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
		s_ack ##0 (req_reg.kind == KIND_ALERT && !LNK_NACK_O)
		|-> LNK_RDATA_O == {DEV_ADDR_I, 1'b1}) else $error("bad response byte");
	a_flags_low_zero: assert property (@(posedge LINK_CLK_I) disable iff (!RSTN_I)
		s_ack ##0 (req_reg.kind == KIND_READ && req_reg.cmd == FLAGS_READ_CMD)
		|-> LNK_RDATA_O[1:0] == 2'b00) else $error("status low bits set");
	a_alert_drive_low: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		ALERT_N_O == 1'b0) else $error("alert data not low");
	a_oe_from_done: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		$rose(ALERT_OE_O) |-> $past(ADC_DONE_I) || $past(ADC_DONE_I, 2))
		else $error("alert without conversion");
	a_start_single: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		CONV_START_O |=> !CONV_START_O until (ADC_DONE_I || !HW_SLEEP_N_I))
		else $error("start during conversion");
	a_sleep_blocks: assert property (@(posedge MCLK_I) disable iff (!RSTN_I)
		!HW_SLEEP_N_I [*5] |-> !CONV_START_O) else $error("start in sleep");
endmodule : tmc_checker

/* test/tmc_host.sv */
// Link-side host model issuing one-byte transfers
`timescale 1ns/100ps
module tmc_host
	import tmc_pkg::*;
(
	input wire logic link_clk_i,
	input wire logic busy_i,
	input wire logic ack_i,
	input wire logic nack_i,
	input wire logic [7:0] rdata_i,
	output logic req_o,
	output tmc_req_s req_data_o
);
	// -------------------------------------------
	// Transfer
	// -------------------------------------------
	initial
	begin
		req_o = 1'b0;
		req_data_o = '1;
	end
	// Released fields inverted so stale values never look valid
	task automatic xfer(input tmc_kind_e k, input logic [7:0] c, input logic [7:0] d,
		output logic [7:0] rdata, output logic nk);
		int n;
		n = 0;
		@(negedge link_clk_i);
		while (busy_i) @(negedge link_clk_i);
		req_data_o = {k, c, d};
		req_o = 1'b1;
		@(negedge link_clk_i);
		req_o = 1'b0;
		req_data_o = ~req_data_o;
		while (!ack_i && n < 16)
		begin
			@(negedge link_clk_i);
			n++;
		end
		rdata = ack_i ? rdata_i : 8'hxx;
		nk = ack_i ? nack_i : 1'bx;
	endtask : xfer
endmodule : tmc_host

/* test/tmc_top_tb.sv */
// Self-checking bench of the monitor control block
`timescale 1ns/100ps
module tmc_top_tb;
	import tmc_pkg::*;
	// -------------------------------------------
	// Model and stimulus
	// -------------------------------------------
	localparam int unsigned EC = 40;
	localparam int CL = 30;
	localparam logic [6:0] OWN_ADDR = 7'h33;
	localparam logic [7:0] LIMS [4] = '{8'h19, 8'hE7, 8'h32, 8'hCE};
	localparam tmc_adc_s ADCS [5] = '{'{8'h19, 8'h00, 1'b0}, '{8'h00, 8'hCE, 1'b0},
		'{8'hE7, 8'h32, 1'b0}, '{8'h18, 8'hE8, 1'b0}, '{8'h00, 8'h00, 1'b1}};
	logic mclk, lclk, rstn, sleep_n, req, conv, done, busy, ack, nack, al_n, al_oe, rn;
	logic [7:0] rdat, rd, sd;
	tmc_req_s rq;
	tmc_adc_s adc;
	int failures, n_tests, cnt, ns, m_flags, m_trip, m_alert;
	int lim [4];
	int ts[$];
	tmc_top #(.EIGHTH_CYC(EC)) DUT (.MCLK_I(mclk), .RSTN_I(rstn), .LINK_CLK_I(lclk),
		.HW_SLEEP_N_I(sleep_n), .DEV_ADDR_I(OWN_ADDR), .LNK_REQ_I(req), .LNK_REQ_DATA_I(rq),
		.LNK_BUSY_O(busy), .LNK_ACK_O(ack), .LNK_NACK_O(nack), .LNK_RDATA_O(rdat),
		.CONV_START_O(conv), .ADC_DONE_I(done), .ADC_I(adc), .ALERT_N_O(al_n),
		.ALERT_OE_O(al_oe));
	tmc_host HOST (.link_clk_i(lclk), .busy_i(busy), .ack_i(ack), .nack_i(nack),
		.rdata_i(rdat), .req_o(req), .req_data_o(rq));
	initial
	begin
		mclk = 0;
		forever #20 mclk = ~mclk;
	end
	initial
	begin
		lclk = 0;
		#7;
		forever #40 lclk = ~lclk;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	function automatic int trips();
		int l;
		int r;
		l = int'($signed(adc.local_t));
		r = int'($signed(adc.remote_t));
		return (int'(l >= lim[0]) << 6) | (int'(l <= lim[1]) << 5) | (int'(r >= lim[2]) << 4)
			| (int'(r <= lim[3]) << 3) | (int'(adc.open) << 2);
	endfunction : trips
	// Converter: fixed length, aborted by hardware sleep
	always @(negedge mclk)
	begin
		done = (cnt == 1) && sleep_n;
		if (done)
		begin
			m_trip = trips();
			m_flags = m_flags | m_trip;
			m_alert = m_alert | int'(m_trip != 0);
		end
		cnt = (cnt > 0 && sleep_n) ? cnt - 1 : 0;
		if (conv)
		begin
			cnt = CL;
			ts.push_back(int'($time / 40));
		end
	end
	task automatic end_of_test();
		if (failures == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic xfer(input tmc_kind_e k, input logic [7:0] c, input logic [7:0] d);
		HOST.xfer(k, c, d, rd, rn);
	endtask : xfer
	task automatic rd_chk(input logic [7:0] c, input logic [7:0] e);
		xfer(KIND_READ, c, 8'h00);
		check(rd, e);
	endtask : rd_chk
	task automatic flags_rd();
		rd_chk(FLAGS_READ_CMD, 8'(m_flags));
		m_flags = m_trip | (m_flags & 4);
	endtask : flags_rd
	task automatic alert_rd();
		xfer(KIND_ALERT, 8'h00, 8'h00);
		check({15'h0000, rn}, 16'(m_alert == 0));
		if (m_alert != 0) check(rd, {OWN_ADDR, 1'b1});
		m_alert = int'(m_trip != 0 || m_flags[2]);
	endtask : alert_rd
	task automatic wr_lim(input int i, input logic [7:0] v);
		xfer(KIND_WRITE, LOCAL_UPPER_WRITE_CMD + 8'(i), v);
		lim[i] = int'($signed(v));
		rd_chk(LOCAL_UPPER_READ_CMD + 8'(i), v);
	endtask : wr_lim
	// Second one-shot lands inside the first conversion and must vanish
	task automatic one_shot(input int n);
		int s;
		s = ts.size();
		repeat (n) xfer(KIND_SEND, SINGLE_CONVERSION_CMD, 8'h00);
		repeat (2 * CL) @(negedge mclk);
		check(16'(ts.size() - s), 16'(sleep_n));
	endtask : one_shot
	initial
	begin
		#(70000 * 40);
		failures++;
		end_of_test();
	end
	initial
	begin
		rstn = 0;
		sleep_n = 1;
		adc = '0;
		{cnt, failures, n_tests, m_flags, m_trip, m_alert} = '0;
		sd = 8'h48;
		lim = '{127, -55, 127, -55};
		repeat (2) @(negedge mclk);
		rstn = 1;
		repeat (4) @(negedge lclk);
		rd_chk(INTERVAL_READ_CMD, INTERVAL_RST);
		for (int i = 0; i < 4; i++)
			rd_chk(LOCAL_UPPER_READ_CMD + 8'(i), i[0] ? LOWER_RST : UPPER_RST);
		xfer(KIND_WRITE, CONFIG_WRITE_CMD, 8'h40);
		repeat (2 * CL) @(negedge mclk);
		flags_rd();
		for (int i = 0; i < 8; i++)
		begin
			sd = lfsr(sd);
			wr_lim(i % 4, sd);
		end
		for (int i = 0; i < 4; i++) wr_lim(i, LIMS[i]);
		for (int i = 0; i < 5; i++)
		begin
			adc = ADCS[i];
			one_shot(2);
			rd_chk(LOCAL_RESULT_CMD, adc.local_t);
			check(al_oe, 16'(m_alert));
			adc = '0;
			one_shot(1);
			flags_rd();
			flags_rd();
			check(al_oe, 16'(m_alert));
			alert_rd();
			repeat (4) @(negedge mclk);
			check(al_oe, 16'(m_alert));
			alert_rd();
		end
		adc = ADCS[0];
		xfer(KIND_SEND, SINGLE_CONVERSION_CMD, 8'h00);
		sleep_n = 0;
		repeat (8) @(negedge mclk);
		one_shot(1);
		rd_chk(LOCAL_RESULT_CMD, 8'h00);
		flags_rd();
		sleep_n = 1;
		ns = ts.size();
		repeat (1500) @(negedge mclk);
		check(16'(ts.size()), 16'(ns));
		xfer(KIND_WRITE, CONFIG_WRITE_CMD, 8'h00);
		for (int r = 7; r >= 0; r--)
		begin
			sd = lfsr(sd);
			xfer(KIND_WRITE, INTERVAL_WRITE_CMD, {sd[7:3], 3'(r)});
			rd_chk(INTERVAL_READ_CMD, {sd[7:3], 3'(r)});
			ns = ts.size() + 2;
			for (int w = 0; w < 12000 && ts.size() < ns; w++) @(negedge mclk);
			check(16'(ts[ns - 1] - ts[ns - 2]), 16'(EC << (7 - r)));
		end
		repeat (2 * CL) @(negedge mclk);
		ns = ts.size();
		xfer(KIND_SEND, SINGLE_CONVERSION_CMD, 8'h00);
		repeat (CL) @(negedge mclk);
		check(16'(ts.size() - ns), 16'h0001);
		xfer(KIND_WRITE, CONFIG_WRITE_CMD, 8'h80);
		check(al_oe, 16'h0000);
		end_of_test();
	end
endmodule : tmc_top_tb
bind tmc_top tmc_checker CHK (.MCLK_I, .RSTN_I, .LINK_CLK_I, .HW_SLEEP_N_I, .DEV_ADDR_I,
	.LNK_REQ_I, .LNK_REQ_DATA_I, .LNK_BUSY_O, .LNK_ACK_O, .LNK_NACK_O, .LNK_RDATA_O,
	.CONV_START_O, .ADC_DONE_I, .ADC_I, .ALERT_N_O, .ALERT_OE_O);
